/* File: gis_pkg.sv */
// constants and register map of the global status and interrupt block
package gis_pkg;

  localparam int GIS_ADDR_W = 10;
  localparam int GIS_DATA_W = 16;

  localparam logic [9:0] GIS_OFS_SUMMARY = 10'h010;
  localparam logic [9:0] GIS_OFS_SUMMARY_EN = 10'h012;
  localparam logic [9:0] GIS_OFS_LIVE = 10'h014;
  localparam logic [9:0] GIS_OFS_LATCHED = 10'h016;
  localparam logic [9:0] GIS_OFS_STATUS_EN = 10'h018;
  localparam logic [9:0] GIS_OFS_PIN_LEVEL = 10'h01c;

  // summary and summary enable fields
  localparam int GIS_BIT_GLOBAL_SUMMARY = 0;
  localparam int GIS_BIT_PORT_SUMMARY = 4;

  // live status fields
  localparam int GIS_BIT_UPDATE_DONE = 0;
  localparam int GIS_BIT_ADAPTER_UNLOCK = 1;

  // latched status fields
  localparam int GIS_BIT_LAT_UPDATE = 0;
  localparam int GIS_BIT_LAT_UNLOCK = 1;
  localparam int GIS_BIT_LAT_SECOND = 2;
  localparam int GIS_BIT_LAT_ADAPTER_REF_CLOCK = 3;
  localparam int GIS_BIT_LAT_REF8K = 4;
  localparam int GIS_LAT_W = 5;
  localparam int GIS_SRC_EN_W = 3;

  localparam logic [15:0] GIS_RST_ENABLE = 16'h0000;
  localparam logic [15:0] GIS_RST_RDATA = 16'h0000;

  // general-purpose pin select codes
  localparam logic [1:0] GIS_PIN_INPUT = 2'h0;
  localparam logic [1:0] GIS_PIN_STATUS = 2'h1;
  localparam logic [1:0] GIS_PIN_LOW = 2'h2;
  localparam logic [1:0] GIS_PIN_HIGH = 2'h3;

  // index of each pin-side input inside the synchroniser vector
  localparam int GIS_PIN_N = 8;
  localparam int GIS_PIN_REF8K = 3;
  localparam int GIS_SYNC_UNLOCK = 8;
  localparam int GIS_SYNC_ADAPTER_REF_CLOCK = 9;
  localparam int GIS_SYNC_W = 10;

  localparam longint GIS_CLOCK_PERIOD_PS = 8000;
  localparam longint GIS_ONE_SECOND_PS = 64'h0000_00e8_d4a5_1000;
  localparam longint GIS_ONE_SECOND_CYCLES = GIS_ONE_SECOND_PS / GIS_CLOCK_PERIOD_PS;
  localparam int GIS_SEC_CNT_W = 27;

endpackage : gis_pkg

/* File: gis_global_status.sv */
// global status latching, interrupt aggregation and general-purpose pin logic
//
// Function
// - pin 1 select 01 drives port status, 10 drives low, 11 drives high.
// - port summary bit 4 is set while any port interrupt status bit is set.
// - interrupt pin low while port summary set and its enable is 1.
// - global summary bit 0 set when an enabled latched global bit is set.
// - interrupt pin low while global summary set and global summary enable is 1.
// - live bit 1 reports clock adapter loss of lock.
// - live bit 0 is AND of update-done flags of globally updated ports and the global update request.
// - latched bit 4 catches 8 kHz activity on pin 4, only when selected.
// - latched bit 3 catches activity on the adapter reference clock.
// - latched bit 2 is set once every second.
// - latched unlock and update bits set only on rising live status.
// - latched bits 0..2 with their enable set raise the global summary.
// - second and update bits reach the pin only with both enables set.
// - interrupt enables: 0 disabled, 1 enabled, reset to 0.
// - read register bits 7..0 return levels of pins 8..1.
`timescale 1ns/10ps
module gis_global_status
  import gis_pkg::*;
#(
  parameter longint ONE_SECOND_CYCLES = GIS_ONE_SECOND_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [GIS_ADDR_W-1:0] i_addr,
  input wire logic [GIS_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [GIS_DATA_W-1:0] o_rdata,
  input wire logic [GIS_DATA_W-1:0] i_port_irq_status,
  input wire logic i_port_update_done,
  input wire logic i_monitor_update_mode,
  input wire logic i_global_monitor_update_request,
  input wire logic i_adapter_unlock,
  input wire logic i_adapter_ref_clock,
  input wire logic i_ref8k_input_select,
  input wire logic [1:0] i_pin1_select,
  input wire logic i_port_status_pin,
  input wire logic [GIS_PIN_N-1:0] i_pin_level,
  output logic o_pin1_out,
  output logic o_pin1_oe,
  output logic o_irq_n
);

  ////////////////////////////////////////////////////////////////////////////
  // pin-side synchronisers: a change counts once stages two and three agree

  logic [GIS_SYNC_W-1:0] sync_in;
  logic [GIS_SYNC_W-1:0] sync1_r;
  logic [GIS_SYNC_W-1:0] sync2_r;
  logic [GIS_SYNC_W-1:0] sync3_r;
  logic [GIS_SYNC_W-1:0] filt_r;
  logic [GIS_SYNC_W-1:0] filt_prev_r;
  logic [GIS_SYNC_W-1:0] filt_nxt;
  logic [GIS_SYNC_W-1:0] toggled;

  assign sync_in = {i_adapter_ref_clock, i_adapter_unlock, i_pin_level};
  assign filt_nxt = (sync2_r & ~(sync2_r ^ sync3_r)) | (filt_r & (sync2_r ^ sync3_r));
  assign toggled = filt_r ^ filt_prev_r;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      filt_r <= '0;
      filt_prev_r <= '0;
    end else begin
      sync1_r <= sync_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      filt_r <= filt_nxt;
      filt_prev_r <= filt_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // live status

  logic unlock_live;
  logic update_done_live;
  logic unlock_prev_r;
  logic update_prev_r;

  assign unlock_live = filt_r[GIS_SYNC_UNLOCK];
  // a port left in port mode does not hold the AND low; request low reads 0
  assign update_done_live = i_global_monitor_update_request &
                            (i_port_update_done | ~i_monitor_update_mode);

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      unlock_prev_r <= 1'h0;
      update_prev_r <= 1'h0;
    end else begin
      unlock_prev_r <= unlock_live;
      update_prev_r <= update_done_live;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one-second reference

  logic [GIS_SEC_CNT_W-1:0] sec_cnt_r;
  logic sec_tick;

  assign sec_tick = (sec_cnt_r == GIS_SEC_CNT_W'(ONE_SECOND_CYCLES - 1));

  always_ff @(posedge i_clock) begin
    if (i_rst || sec_tick) begin
      sec_cnt_r <= '0;
    end else begin
      sec_cnt_r <= sec_cnt_r + 1'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  logic wr_summary_en;
  logic wr_status_en;
  logic wr_latched;

  assign wr_summary_en = i_wr && (i_addr == GIS_OFS_SUMMARY_EN);
  assign wr_status_en = i_wr && (i_addr == GIS_OFS_STATUS_EN);
  assign wr_latched = i_wr && (i_addr == GIS_OFS_LATCHED);

  logic port_summary_enable_r;
  logic global_summary_enable_r;
  logic [GIS_SRC_EN_W-1:0] src_enable_r;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      port_summary_enable_r <= GIS_RST_ENABLE[GIS_BIT_PORT_SUMMARY];
      global_summary_enable_r <= GIS_RST_ENABLE[GIS_BIT_GLOBAL_SUMMARY];
    end else if (wr_summary_en) begin
      port_summary_enable_r <= i_wdata[GIS_BIT_PORT_SUMMARY];
      global_summary_enable_r <= i_wdata[GIS_BIT_GLOBAL_SUMMARY];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      src_enable_r <= GIS_RST_ENABLE[GIS_SRC_EN_W-1:0];
    end else if (wr_status_en) begin
      src_enable_r <= i_wdata[GIS_SRC_EN_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // latched status: write one to clear, a set in the same cycle wins

  logic [GIS_LAT_W-1:0] latched_r;
  logic [GIS_LAT_W-1:0] latched_set;
  logic [GIS_LAT_W-1:0] latched_clr;

  always_comb begin
    latched_set = '0;
    latched_set[GIS_BIT_LAT_UPDATE] = update_done_live & ~update_prev_r;
    latched_set[GIS_BIT_LAT_UNLOCK] = unlock_live & ~unlock_prev_r;
    latched_set[GIS_BIT_LAT_SECOND] = sec_tick;
    latched_set[GIS_BIT_LAT_ADAPTER_REF_CLOCK] = toggled[GIS_SYNC_ADAPTER_REF_CLOCK];
    latched_set[GIS_BIT_LAT_REF8K] = toggled[GIS_PIN_REF8K] & i_ref8k_input_select;
  end

  assign latched_clr = wr_latched ? i_wdata[GIS_LAT_W-1:0] : '0;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      latched_r <= '0;
    end else begin
      latched_r <= (latched_r & ~latched_clr) | latched_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // summary and interrupt pin

  logic port_summary_flag;
  logic global_summary_flag;

  assign port_summary_flag = |i_port_irq_status;
  // only bits 0..2 have enables, so activity bits never interrupt
  assign global_summary_flag = |(latched_r[GIS_SRC_EN_W-1:0] & src_enable_r);

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_irq_n <= 1'h1;
    end else begin
      o_irq_n <= ~((port_summary_flag & port_summary_enable_r) |
                   (global_summary_flag & global_summary_enable_r));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // general-purpose pin 1 drive

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pin1_out <= 1'h0;
      o_pin1_oe <= 1'h0;
    end else begin
      case (i_pin1_select)
        GIS_PIN_STATUS: begin
          o_pin1_out <= i_port_status_pin;
          o_pin1_oe <= 1'h1;
        end
        GIS_PIN_LOW: begin
          o_pin1_out <= 1'h0;
          o_pin1_oe <= 1'h1;
        end
        GIS_PIN_HIGH: begin
          o_pin1_out <= 1'h1;
          o_pin1_oe <= 1'h1;
        end
        default: begin
          o_pin1_out <= 1'h0;
          o_pin1_oe <= 1'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads, one cycle after the strobe

  logic [GIS_DATA_W-1:0] rdata_nxt;

  always_comb begin
    rdata_nxt = GIS_RST_RDATA;
    case (i_addr)
      GIS_OFS_SUMMARY: begin
        rdata_nxt[GIS_BIT_PORT_SUMMARY] = port_summary_flag;
        rdata_nxt[GIS_BIT_GLOBAL_SUMMARY] = global_summary_flag;
      end
      GIS_OFS_SUMMARY_EN: begin
        rdata_nxt[GIS_BIT_PORT_SUMMARY] = port_summary_enable_r;
        rdata_nxt[GIS_BIT_GLOBAL_SUMMARY] = global_summary_enable_r;
      end
      GIS_OFS_LIVE: begin
        rdata_nxt[GIS_BIT_ADAPTER_UNLOCK] = unlock_live;
        rdata_nxt[GIS_BIT_UPDATE_DONE] = update_done_live;
      end
      GIS_OFS_LATCHED: begin
        rdata_nxt[GIS_LAT_W-1:0] = latched_r;
      end
      GIS_OFS_STATUS_EN: begin
        rdata_nxt[GIS_SRC_EN_W-1:0] = src_enable_r;
      end
      GIS_OFS_PIN_LEVEL: begin
        rdata_nxt[GIS_PIN_N-1:0] = filt_r[GIS_PIN_N-1:0];
      end
      default: begin
        rdata_nxt = GIS_RST_RDATA;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_rdata <= GIS_RST_RDATA;
    end else if (i_rd) begin
      o_rdata <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  irq_port_path_a: assert property (
    (port_summary_flag && port_summary_enable_r) |=> !o_irq_n)
    else $error("port summary enabled but interrupt pin high");

  irq_global_path_a: assert property (
    (latched_r[GIS_BIT_LAT_SECOND] && src_enable_r[GIS_BIT_LAT_SECOND] &&
     global_summary_enable_r) |=> !o_irq_n)
    else $error("enabled second bit did not pull interrupt pin low");

  irq_release_a: assert property (
    (!(port_summary_flag && port_summary_enable_r) &&
     !(global_summary_flag && global_summary_enable_r)) |=> o_irq_n)
    else $error("interrupt pin low with no enabled source");

  summary_gate_a: assert property (
    (latched_r[GIS_BIT_LAT_UNLOCK] && src_enable_r[GIS_BIT_LAT_UNLOCK]) |-> global_summary_flag)
    else $error("enabled unlock bit did not raise global summary");

  unlock_edge_a: assert property (
    (!latched_r[GIS_BIT_LAT_UNLOCK] && !$rose(unlock_live)) |=> !latched_r[GIS_BIT_LAT_UNLOCK])
    else $error("unlock latch set without a rising live bit");

  update_latch_a: assert property (
    $rose(update_done_live) |=> latched_r[GIS_BIT_LAT_UPDATE])
    else $error("rising update status not latched");

  second_tick_a: assert property (
    sec_tick |=> latched_r[GIS_BIT_LAT_SECOND] ##1 !sec_tick)
    else $error("one-second tick not latched or repeated");

  ref8k_gate_a: assert property (
    (!latched_r[GIS_BIT_LAT_REF8K] && !i_ref8k_input_select) |=> !latched_r[GIS_BIT_LAT_REF8K])
    else $error("8 kHz activity latched while not selected");

  enable_reset_a: assert property (disable iff (1'h0)
    i_rst |=> (!port_summary_enable_r && !global_summary_enable_r && src_enable_r == '0))
    else $error("interrupt enables not cleared by reset");

  pin1_drive_a: assert property (
    (i_pin1_select == GIS_PIN_LOW) |=> (o_pin1_oe && !o_pin1_out))
    else $error("pin 1 not driven low for low select");

  pin_level_read_a: assert property (
    (i_rd && i_addr == GIS_OFS_PIN_LEVEL) |=> (o_rdata[GIS_PIN_N-1:0] == $past(filt_r[GIS_PIN_N-1:0])))
    else $error("pin level read-back mismatch");

  pin1_input_a: assert property (
    (i_pin1_select == GIS_PIN_INPUT) |=> !o_pin1_oe)
    else $error("pin 1 driven while select is input");

  pin1_status_a: assert property (
    (i_pin1_select == GIS_PIN_STATUS) |=>
    (o_pin1_oe && (o_pin1_out == $past(i_port_status_pin))))
    else $error("pin 1 does not follow port status");

  port_summary_read_a: assert property (
    (i_rd && i_addr == GIS_OFS_SUMMARY) |=>
    (o_rdata[GIS_BIT_PORT_SUMMARY] == ($past(i_port_irq_status) != '0)))
    else $error("port summary bit does not reflect port status");

  adapter_ref_clock_activity_a: assert property (
    toggled[GIS_SYNC_ADAPTER_REF_CLOCK] |=> latched_r[GIS_BIT_LAT_ADAPTER_REF_CLOCK])
    else $error("reference clock activity not latched");

  update_gate_a: assert property (
    (i_monitor_update_mode && !i_port_update_done) |-> !update_done_live)
    else $error("update status high while a port is still busy");

  unlock_live_read_a: assert property (
    (i_rd && i_addr == GIS_OFS_LIVE) |=>
    (o_rdata[GIS_BIT_ADAPTER_UNLOCK] == $past(filt_r[GIS_SYNC_UNLOCK])))
    else $error("live unlock bit read-back mismatch");

endmodule : gis_global_status

/* File: gis_host_model.sv */
// host model: register accesses and global update request
`timescale 1ns/10ps
module gis_host_model
  import gis_pkg::*;
(
  input wire logic i_clock,
  input wire logic [GIS_DATA_W-1:0] i_rdata,
  output logic [GIS_ADDR_W-1:0] o_addr,
  output logic [GIS_DATA_W-1:0] o_wdata,
  output logic o_wr,
  output logic o_rd,
  output logic o_update_request
);
  initial begin
    o_addr = 10'h000;
    o_wdata = 16'h0000;
    o_wr = 1'h0;
    o_rd = 1'h0;
    o_update_request = 1'h0;
  end

  task automatic write_reg(input logic [9:0] addr, input logic [15:0] data);
    @(negedge i_clock);
    o_addr = addr;
    o_wdata = data;
    o_wr = 1'h1;
    @(negedge i_clock);
    o_wr = 1'h0;
    // stale data is not left looking valid
    o_wdata = ~data;
  endtask : write_reg

  task automatic read_reg(input logic [9:0] addr, output logic [15:0] data);
    @(negedge i_clock);
    o_addr = addr;
    o_rd = 1'h1;
    @(negedge i_clock);
    o_rd = 1'h0;
    data = i_rdata;
  endtask : read_reg

  // request stays up until the live done bit is seen high, or the poll gives up
  task automatic run_update(output logic ok);
    logic [15:0] d;
    ok = 1'h0;
    o_update_request = 1'h1;
    for (int i = 0; i < 40 && !ok; i++) begin
      read_reg(GIS_OFS_LIVE, d);
      ok = d[GIS_BIT_UPDATE_DONE];
    end
    o_update_request = 1'h0;
  endtask : run_update
endmodule : gis_host_model

/* File: tb_top.sv */
// self-checking testbench of the global status and interrupt block
`timescale 1ns/10ps
module tb_top
  import gis_pkg::*;
;
  localparam int SEC = 20;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic [9:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic wr_strobe;
  logic rd;
  logic req;
  logic [15:0] port_irq = 16'h0000;
  logic done = 1'h0;
  logic mode = 1'h0;
  logic unlock = 1'h0;
  logic adapter_ref_clock = 1'h0;
  logic sel8k = 1'h0;
  logic [1:0] pin1_sel = 2'h0;
  logic status_pin = 1'h0;
  logic [7:0] pins_in = 8'h00;
  logic [7:0] pin_level;
  logic pin1_out;
  logic pin1_oe;
  logic irq_n;
  logic ok;
  int miscompares = 0;
  int checks_done = 0;

  always #4 clock = ~clock;
  // pin 1 sees its own drive while the block drives it
  assign pin_level = {pins_in[7:1], pin1_oe ? pin1_out : pins_in[0]};

  gis_global_status #(.ONE_SECOND_CYCLES(SEC)) u_gis_global_status (
    .i_clock(clock), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_strobe),
    .i_rd(rd), .o_rdata(rdata), .i_port_irq_status(port_irq),
    .i_port_update_done(done), .i_monitor_update_mode(mode),
    .i_global_monitor_update_request(req), .i_adapter_unlock(unlock),
    .i_adapter_ref_clock(adapter_ref_clock), .i_ref8k_input_select(sel8k),
    .i_pin1_select(pin1_sel), .i_port_status_pin(status_pin),
    .i_pin_level(pin_level), .o_pin1_out(pin1_out), .o_pin1_oe(pin1_oe),
    .o_irq_n(irq_n)
  );

  gis_host_model u_gis_host_model (
    .i_clock(clock), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr_strobe), .o_rd(rd), .o_update_request(req)
  );

  ////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  task automatic rd_chk(input logic [9:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] d;
    u_gis_host_model.read_reg(a, d);
    chk16(d & m, e);
  endtask : rd_chk

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    u_gis_host_model.write_reg(a, d);
  endtask : wr

  task automatic wait_cycles(input int n);
    repeat (n) @(negedge clock);
  endtask : wait_cycles

  ////////////////////////////////////////////////////////////
  initial begin
    wait_cycles(2);
    rst = 1'h0;
    rd_chk(GIS_OFS_SUMMARY_EN, 16'hffff, 16'h0000);
    rd_chk(GIS_OFS_STATUS_EN, 16'hffff, 16'h0000);
    rd_chk(10'h01e, 16'hffff, 16'h0000);
    chk1(irq_n, 1'h1);
    port_irq = 16'h8000;
    rd_chk(GIS_OFS_SUMMARY, 16'h0010, 16'h0010);
    wr(GIS_OFS_SUMMARY_EN, 16'hffff);
    rd_chk(GIS_OFS_SUMMARY_EN, 16'hffff, 16'h0011);
    wait_cycles(2);
    chk1(irq_n, 1'h0);
    port_irq = 16'h0000;
    wait_cycles(2);
    chk1(irq_n, 1'h1);
    // second tick latched but not enabled: no summary
    wait_cycles(SEC + 5);
    rd_chk(GIS_OFS_LATCHED, 16'h0004, 16'h0004);
    rd_chk(GIS_OFS_SUMMARY, 16'h0011, 16'h0000);
    wr(GIS_OFS_STATUS_EN, 16'hffff);
    rd_chk(GIS_OFS_STATUS_EN, 16'hffff, 16'h0007);
    wait_cycles(SEC + 5);
    chk1(irq_n, 1'h0);
    rd_chk(GIS_OFS_SUMMARY, 16'h0001, 16'h0001);
    wr(GIS_OFS_SUMMARY_EN, 16'h0010);
    wait_cycles(2);
    chk1(irq_n, 1'h1);
    wr(GIS_OFS_STATUS_EN, 16'h0003);
    wr(GIS_OFS_LATCHED, 16'h001f);
    rd_chk(GIS_OFS_SUMMARY, 16'h0001, 16'h0000);
    unlock = 1'h1;
    wait_cycles(6);
    rd_chk(GIS_OFS_LIVE, 16'h0002, 16'h0002);
    rd_chk(GIS_OFS_LATCHED, 16'h0002, 16'h0002);
    rd_chk(GIS_OFS_SUMMARY, 16'h0001, 16'h0001);
    wr(GIS_OFS_LATCHED, 16'h0002);
    rd_chk(GIS_OFS_LATCHED, 16'h0002, 16'h0000);
    unlock = 1'h0;
    wait_cycles(6);
    rd_chk(GIS_OFS_LIVE, 16'h0002, 16'h0000);
    mode = 1'h1;
    u_gis_host_model.run_update(ok);
    chk1(ok, 1'h0);
    done = 1'h1;
    u_gis_host_model.run_update(ok);
    chk1(ok, 1'h1);
    rd_chk(GIS_OFS_LATCHED, 16'h0001, 16'h0001);
    rd_chk(GIS_OFS_LIVE, 16'h0001, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      adapter_ref_clock = ~adapter_ref_clock;
      wait_cycles(2);
    end
    wait_cycles(6);
    rd_chk(GIS_OFS_LATCHED, 16'h0008, 16'h0008);
    for (int s = 0; s < 2; s++) begin
      sel8k = s[0];
      wait_cycles(6);
      wr(GIS_OFS_LATCHED, 16'h0010);
      for (int i = 0; i < 4; i++) begin
        pins_in[3] = ~pins_in[3];
        wait_cycles(2);
      end
      wait_cycles(6);
      rd_chk(GIS_OFS_LATCHED, 16'h0010, {11'h000, s[0], 4'h0});
    end
    for (int k = 0; k < 4; k++) begin
      pin1_sel = k[1:0];
      wait_cycles(2);
      chk1(pin1_oe, k != 0);
      if (k != 0) chk1(pin1_out, k == 3);
    end
    status_pin = 1'h1;
    pin1_sel = 2'h1;
    wait_cycles(2);
    chk1(pin1_out, 1'h1);
    pin1_sel = 2'h2;
    pins_in = 8'ha5;
    wait_cycles(6);
    rd_chk(GIS_OFS_PIN_LEVEL, 16'hffff, 16'h00a4);
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    print_verdict();
  end
endmodule : tb_top
